// File: rtl/pidc_top.sv
// The implementer's own choices: the address map and register access over APB.
module pidc_top
#(
   parameter int unsigned SAMPLE_CYCLES = pidc_pkg::SAMPLE_CYC
)
(
   input wire logic core_clk,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [15:0] voltage_analog_input,
   input wire logic [15:0] current_analog_input,
   input wire logic [15:0] multi_step_setpoint,
   input wire logic drive_running,
   output logic [15:0] freq_command,
   output logic pid_active,
   output logic feedback_warning,
   output logic ramp_stop_req,
   output logic coast_stop_req,
   output logic irq
);
   // Analog inputs are in 0.01 % units (10000 = 100 %)
   logic [15:0] vin_s1_r, vin_s2_r, cin_s1_r, cin_s2_r, ms_s1_r, ms_s2_r;
   logic run_s1_r, run_s2_r;
   logic [15:0] src_r, src_nxt, fbgain_r, fbgain_nxt, pgain_r, pgain_nxt;
   logic [15:0] itime_r, itime_nxt, dtime_r, dtime_nxt, ibound_r, ibound_nxt;
   logic [15:0] dfilt_r, dfilt_nxt, olimit_r, olimit_nxt, detect_r, detect_nxt;
   logic [15:0] action_r, action_nxt, devrange_r, devrange_nxt, maxf_r, maxf_nxt;
   logic [15:0] fsrc_r, fsrc_nxt, keypad_r, keypad_nxt;
   logic [pidc_pkg::N_EVT-1:0] status_r, status_nxt, mask_r, mask_nxt, evt;
   logic [31:0] prdata_r, prdata_nxt;
   logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
   logic [31:0] tick_cnt_r, tick_cnt_nxt;
   logic [7:0] ds_cnt_r, ds_cnt_nxt;
   logic [15:0] abn_cnt_r, abn_cnt_nxt;
   logic warn_r, warn_nxt, ramp_r, ramp_nxt, coast_r, coast_nxt, act_r, act_nxt;
   logic [15:0] fout_r, fout_nxt;
   logic irq_r, irq_nxt;
   logic tick_r, tick_nxt;
   typedef pidc_pkg::pidc_state_e pidc_state_local_e;
   pidc_state_local_e state_r, state_nxt;
   logic signed [31:0] dev_r, dev_nxt, tgt, fb_raw, fb;
   logic [31:0] fb_wide;
   logic neg_fb, pid_en, wr, rd, mapped;
   logic signed [31:0] sum, lim, fcalc;
   logic [31:0] ilim_w, olim_w;
   logic signed [31:0] err_mag;
   pidc_cfg_if cfg ();

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         vin_s1_r <= 16'h0000;
         vin_s2_r <= 16'h0000;
         cin_s1_r <= 16'h0000;
         cin_s2_r <= 16'h0000;
         ms_s1_r <= 16'h0000;
         ms_s2_r <= 16'h0000;
         run_s1_r <= 1'b0;
         run_s2_r <= 1'b0;
      end
      else
      begin
         // Two-flop capture of pin inputs; multi-bit values assumed slow-moving
         vin_s1_r <= voltage_analog_input;
         vin_s2_r <= vin_s1_r;
         cin_s1_r <= current_analog_input;
         cin_s2_r <= cin_s1_r;
         ms_s1_r <= multi_step_setpoint;
         ms_s2_r <= ms_s1_r;
         run_s1_r <= drive_running;
         run_s2_r <= run_s1_r;
      end
   end

   assign pid_en = (src_r >= pidc_pkg::SRC_AVI_NEG) && (src_r <= pidc_pkg::SRC_ACI_POS);
   assign neg_fb = (src_r == pidc_pkg::SRC_AVI_NEG) || (src_r == pidc_pkg::SRC_ACI_NEG);
   assign fb_raw = ((src_r == pidc_pkg::SRC_AVI_NEG) || (src_r == pidc_pkg::SRC_AVI_POS)) ?
                   $signed({16'h0000, vin_s2_r}) : $signed({16'h0000, cin_s2_r});
   assign fb_wide = 32'(fb_raw) * {16'h0000, fbgain_r} / 32'h00000064;
   assign fb = $signed(fb_wide);
   assign tgt = (fsrc_r == pidc_pkg::FSRC_KEYPAD) ? $signed({16'h0000, keypad_r}) :
                $signed({16'h0000, ms_s2_r});
   assign err_mag = (tgt > fb) ? (tgt - fb) : (fb - tgt);
   assign ilim_w = {16'h0000, ibound_r} * 32'h00000064;
   assign olim_w = {16'h0000, olimit_r} * 32'h00000064;
   assign sum = cfg.p_term + cfg.i_acc + cfg.d_term;
   assign lim = $signed(olim_w);
   assign fcalc = (sum > lim) ? lim : ((sum < 32'sh0) ? 32'sh0 : sum);

   assign cfg.pgain = pgain_r;
   assign cfg.itime = itime_r;
   assign cfg.dtime = dtime_r;
   assign cfg.dfilt = dfilt_r;
   assign cfg.tick = tick_r;
   assign cfg.clr = ~pid_en;
   assign cfg.dev = dev_r;
   assign cfg.i_lim = $signed(ilim_w);

   pidc_terms u_terms
   (
      .core_clk(core_clk),
      .srst(srst),
      .cfg(cfg)
   );

   assign wr = psel && penable && pwrite;
   assign rd = psel && !penable && !pwrite;
   assign mapped = (paddr <= pidc_pkg::ADDR_CTRL) && (paddr[1:0] == 2'b00);

   always_comb
   begin
      src_nxt = src_r;
      fbgain_nxt = fbgain_r;
      pgain_nxt = pgain_r;
      itime_nxt = itime_r;
      dtime_nxt = dtime_r;
      ibound_nxt = ibound_r;
      dfilt_nxt = dfilt_r;
      olimit_nxt = olimit_r;
      detect_nxt = detect_r;
      action_nxt = action_r;
      devrange_nxt = devrange_r;
      maxf_nxt = maxf_r;
      fsrc_nxt = fsrc_r;
      keypad_nxt = keypad_r;
      mask_nxt = mask_r;
      status_nxt = status_r;
      prdata_nxt = prdata_r;
      pslverr_nxt = 1'b0;
      // Setup cycle prepares the answer; access phase completes in one cycle
      pready_nxt = psel && !penable;
      if (psel && !penable)
         pslverr_nxt = !mapped;
      if (rd)
      begin
         case (paddr)
            pidc_pkg::ADDR_SRC: prdata_nxt = {16'h0000, src_r};
            pidc_pkg::ADDR_FBGAIN: prdata_nxt = {16'h0000, fbgain_r};
            pidc_pkg::ADDR_PGAIN: prdata_nxt = {16'h0000, pgain_r};
            pidc_pkg::ADDR_ITIME: prdata_nxt = {16'h0000, itime_r};
            pidc_pkg::ADDR_DTIME: prdata_nxt = {16'h0000, dtime_r};
            pidc_pkg::ADDR_IBOUND: prdata_nxt = {16'h0000, ibound_r};
            pidc_pkg::ADDR_DFILT: prdata_nxt = {16'h0000, dfilt_r};
            pidc_pkg::ADDR_OLIMIT: prdata_nxt = {16'h0000, olimit_r};
            pidc_pkg::ADDR_DETECT: prdata_nxt = {16'h0000, detect_r};
            pidc_pkg::ADDR_ACTION: prdata_nxt = {16'h0000, action_r};
            pidc_pkg::ADDR_DEVRANGE: prdata_nxt = {16'h0000, devrange_r};
            pidc_pkg::ADDR_MAXFREQ: prdata_nxt = {16'h0000, maxf_r};
            pidc_pkg::ADDR_FSRC: prdata_nxt = {16'h0000, fsrc_r};
            pidc_pkg::ADDR_KEYPAD: prdata_nxt = {16'h0000, keypad_r};
            pidc_pkg::ADDR_OUTFREQ: prdata_nxt = {16'h0000, fout_r};
            pidc_pkg::ADDR_STATUS: prdata_nxt = {28'h0000000, status_r};
            pidc_pkg::ADDR_MASK: prdata_nxt = {28'h0000000, mask_r};
            pidc_pkg::ADDR_CTRL: prdata_nxt = {29'h00000000, act_r, warn_r, pid_en};
            default: prdata_nxt = 32'h00000000;
         endcase
      end
      if (wr && pready_r)
      begin
         case (paddr)
            pidc_pkg::ADDR_SRC: src_nxt = pwdata[15:0];
            pidc_pkg::ADDR_FBGAIN: fbgain_nxt = pwdata[15:0];
            pidc_pkg::ADDR_PGAIN: pgain_nxt = pwdata[15:0];
            pidc_pkg::ADDR_ITIME: itime_nxt = pwdata[15:0];
            pidc_pkg::ADDR_DTIME: dtime_nxt = pwdata[15:0];
            pidc_pkg::ADDR_IBOUND: ibound_nxt = pwdata[15:0];
            pidc_pkg::ADDR_DFILT: dfilt_nxt = pwdata[15:0];
            pidc_pkg::ADDR_OLIMIT: olimit_nxt = pwdata[15:0];
            pidc_pkg::ADDR_DETECT: detect_nxt = pwdata[15:0];
            pidc_pkg::ADDR_ACTION: action_nxt = pwdata[15:0];
            pidc_pkg::ADDR_DEVRANGE: devrange_nxt = pwdata[15:0];
            pidc_pkg::ADDR_MAXFREQ: maxf_nxt = pwdata[15:0];
            pidc_pkg::ADDR_FSRC: fsrc_nxt = pwdata[15:0];
            pidc_pkg::ADDR_KEYPAD: keypad_nxt = pwdata[15:0];
            pidc_pkg::ADDR_STATUS: status_nxt = status_r & ~pwdata[pidc_pkg::N_EVT-1:0];
            pidc_pkg::ADDR_MASK: mask_nxt = pwdata[pidc_pkg::N_EVT-1:0];
            default: ;
         endcase
      end
      // Set beats clear when both land together
      status_nxt = status_nxt | evt;
      irq_nxt = |(status_r & mask_r);
   end

   always_comb
   begin
      tick_cnt_nxt = tick_cnt_r + 32'h00000001;
      tick_nxt = 1'b0;
      ds_cnt_nxt = ds_cnt_r;
      abn_cnt_nxt = abn_cnt_r;
      warn_nxt = warn_r;
      ramp_nxt = ramp_r;
      coast_nxt = coast_r;
      act_nxt = act_r;
      dev_nxt = dev_r;
      fout_nxt = fout_r;
      state_nxt = state_r;
      evt = '0;
      if (tick_cnt_r == 32'(SAMPLE_CYCLES - 1))
      begin
         tick_cnt_nxt = 32'h00000000;
      end
      case (state_r)
         pidc_pkg::PIDC_IDLE:
         begin
            if (tick_cnt_r == 32'(SAMPLE_CYCLES - 1))
            begin
               dev_nxt = neg_fb ? (tgt - fb) : (fb - tgt);
               tick_nxt = 1'b1;
               state_nxt = pidc_pkg::PIDC_CALC;
            end
         end
         pidc_pkg::PIDC_CALC:
            state_nxt = pidc_pkg::PIDC_OUT;
         pidc_pkg::PIDC_OUT:
         begin
            evt[pidc_pkg::ST_SAMPLE] = 1'b1;
            // fcalc is 0.01 % of master frequency; scale to max_output_frequency units
            fout_nxt = pid_en ? 16'(32'(fcalc) * {16'h0000, maxf_r} / 32'(pidc_pkg::PCT100_X100))
                              : 16'h0000;
            act_nxt = pid_en && run_s2_r;
            ds_cnt_nxt = 8'h00;
            // Only an unbroken run of abnormal samples counts, so a short excursion never warns
            if (!act_r || detect_r == 16'h0000)
               abn_cnt_nxt = 16'h0000;
            else if (err_mag > $signed({16'h0000, devrange_r}))
            begin
               if (abn_cnt_r < detect_r)
               begin
                  ds_cnt_nxt = ds_cnt_r + 8'h01;
                  if (ds_cnt_r == 8'(pidc_pkg::SAMPLES_PER_DS - 1))
                  begin
                     ds_cnt_nxt = 8'h00;
                     abn_cnt_nxt = abn_cnt_r + 16'h0001;
                  end
               end
            end
            else
               abn_cnt_nxt = 16'h0000;
            state_nxt = pidc_pkg::PIDC_IDLE;
         end
         default:
            state_nxt = pidc_pkg::PIDC_IDLE;
      endcase
      if (detect_r != 16'h0000 && pid_en && abn_cnt_r >= detect_r && !warn_r)
      begin
         warn_nxt = 1'b1;
         evt[pidc_pkg::ST_WARN] = 1'b1;
         if (action_r == pidc_pkg::ACT_RAMP)
         begin
            ramp_nxt = 1'b1;
            evt[pidc_pkg::ST_RAMP] = 1'b1;
         end
         else if (action_r == pidc_pkg::ACT_COAST)
         begin
            coast_nxt = 1'b1;
            evt[pidc_pkg::ST_COAST] = 1'b1;
         end
      end
      else if (abn_cnt_r < detect_r || detect_r == 16'h0000 || !pid_en)
      begin
         // Warning drops once feedback recovers; stop requests latch until drive halts
         warn_nxt = 1'b0;
         if (!run_s2_r)
         begin
            ramp_nxt = 1'b0;
            coast_nxt = 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         src_r <= pidc_pkg::RST_SRC;
         fbgain_r <= pidc_pkg::RST_FBGAIN;
         pgain_r <= pidc_pkg::RST_PGAIN;
         itime_r <= pidc_pkg::RST_ITIME;
         dtime_r <= pidc_pkg::RST_DTIME;
         ibound_r <= pidc_pkg::RST_IBOUND;
         dfilt_r <= pidc_pkg::RST_DFILT;
         olimit_r <= pidc_pkg::RST_OLIMIT;
         detect_r <= pidc_pkg::RST_DETECT;
         action_r <= pidc_pkg::RST_ACTION;
         devrange_r <= pidc_pkg::RST_DEVRANGE;
         maxf_r <= pidc_pkg::RST_MAXFREQ;
         fsrc_r <= pidc_pkg::FSRC_KEYPAD;
         keypad_r <= 16'h0000;
         mask_r <= '0;
         status_r <= '0;
         prdata_r <= 32'h00000000;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         irq_r <= 1'b0;
         tick_cnt_r <= 32'h00000000;
         tick_r <= 1'b0;
         ds_cnt_r <= 8'h00;
         abn_cnt_r <= 16'h0000;
         warn_r <= 1'b0;
         ramp_r <= 1'b0;
         coast_r <= 1'b0;
         act_r <= 1'b0;
         dev_r <= 32'sh0;
         fout_r <= 16'h0000;
         state_r <= pidc_pkg::PIDC_IDLE;
      end
      else
      begin
         src_r <= src_nxt;
         fbgain_r <= fbgain_nxt;
         pgain_r <= pgain_nxt;
         itime_r <= itime_nxt;
         dtime_r <= dtime_nxt;
         ibound_r <= ibound_nxt;
         dfilt_r <= dfilt_nxt;
         olimit_r <= olimit_nxt;
         detect_r <= detect_nxt;
         action_r <= action_nxt;
         devrange_r <= devrange_nxt;
         maxf_r <= maxf_nxt;
         fsrc_r <= fsrc_nxt;
         keypad_r <= keypad_nxt;
         mask_r <= mask_nxt;
         status_r <= status_nxt;
         prdata_r <= prdata_nxt;
         pready_r <= pready_nxt;
         pslverr_r <= pslverr_nxt;
         irq_r <= irq_nxt;
         tick_cnt_r <= tick_cnt_nxt;
         tick_r <= tick_nxt;
         ds_cnt_r <= ds_cnt_nxt;
         abn_cnt_r <= abn_cnt_nxt;
         warn_r <= warn_nxt;
         ramp_r <= ramp_nxt;
         coast_r <= coast_nxt;
         act_r <= act_nxt;
         dev_r <= dev_nxt;
         fout_r <= fout_nxt;
         state_r <= state_nxt;
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign freq_command = fout_r;
   assign pid_active = act_r;
   assign feedback_warning = warn_r;
   assign ramp_stop_req = ramp_r;
   assign coast_stop_req = coast_r;
   assign irq = irq_r;
endmodule // pidc_top

// File: rtl/pidc_pkg.sv
package pidc_pkg;
   localparam int unsigned CLK_HZ = 125000000;
   localparam int unsigned SAMPLE_US = 1000;
   localparam int unsigned SAMPLE_CYC = CLK_HZ / 1000000 * SAMPLE_US;
   localparam int unsigned SAMPLES_PER_DS = 100;
   localparam logic [11:0] ADDR_SRC = 12'h000;
   localparam logic [11:0] ADDR_FBGAIN = 12'h004;
   localparam logic [11:0] ADDR_PGAIN = 12'h008;
   localparam logic [11:0] ADDR_ITIME = 12'h00C;
   localparam logic [11:0] ADDR_DTIME = 12'h010;
   localparam logic [11:0] ADDR_IBOUND = 12'h014;
   localparam logic [11:0] ADDR_DFILT = 12'h018;
   localparam logic [11:0] ADDR_OLIMIT = 12'h01C;
   localparam logic [11:0] ADDR_DETECT = 12'h020;
   localparam logic [11:0] ADDR_ACTION = 12'h024;
   localparam logic [11:0] ADDR_DEVRANGE = 12'h028;
   localparam logic [11:0] ADDR_MAXFREQ = 12'h02C;
   localparam logic [11:0] ADDR_FSRC = 12'h030;
   localparam logic [11:0] ADDR_KEYPAD = 12'h034;
   localparam logic [11:0] ADDR_OUTFREQ = 12'h038;
   localparam logic [11:0] ADDR_STATUS = 12'h03C;
   localparam logic [11:0] ADDR_MASK = 12'h040;
   localparam logic [11:0] ADDR_CTRL = 12'h044;
   localparam logic [15:0] RST_SRC = 16'h0000;
   localparam logic [15:0] RST_FBGAIN = 16'h0064;
   localparam logic [15:0] RST_PGAIN = 16'h000A;
   localparam logic [15:0] RST_ITIME = 16'h0064;
   localparam logic [15:0] RST_DTIME = 16'h0000;
   localparam logic [15:0] RST_IBOUND = 16'h0064;
   localparam logic [15:0] RST_DFILT = 16'h0000;
   localparam logic [15:0] RST_OLIMIT = 16'h0064;
   localparam logic [15:0] RST_DETECT = 16'h0258;
   localparam logic [15:0] RST_ACTION = 16'h0000;
   localparam logic [15:0] RST_DEVRANGE = 16'h2710;
   localparam logic [15:0] RST_MAXFREQ = 16'h1770;
   localparam logic [15:0] SRC_AVI_NEG = 16'h0001;
   localparam logic [15:0] SRC_ACI_NEG = 16'h0002;
   localparam logic [15:0] SRC_AVI_POS = 16'h0003;
   localparam logic [15:0] SRC_ACI_POS = 16'h0004;
   localparam logic [15:0] FSRC_KEYPAD = 16'h0000;
   localparam logic [15:0] ACT_RAMP = 16'h0001;
   localparam logic [15:0] ACT_COAST = 16'h0002;
   localparam logic [15:0] PCT100_X100 = 16'h2710;
   localparam int unsigned FB_GAIN_SHIFT = 0;
   localparam int unsigned ST_WARN = 0;
   localparam int unsigned ST_RAMP = 1;
   localparam int unsigned ST_COAST = 2;
   localparam int unsigned ST_SAMPLE = 3;
   localparam int unsigned N_EVT = 4;
   typedef enum logic [1:0] {PIDC_IDLE, PIDC_CALC, PIDC_OUT} pidc_state_e;
endpackage

// File: rtl/pidc_cfg_if.sv
interface pidc_cfg_if;
   logic [15:0] pgain;
   logic [15:0] itime;
   logic [15:0] dtime;
   logic [15:0] dfilt;
   logic tick;
   logic clr;
   logic signed [31:0] dev;
   logic signed [31:0] p_term;
   logic signed [31:0] i_acc;
   logic signed [31:0] d_term;
   logic signed [31:0] i_lim;
   modport ctrl (output pgain, itime, dtime, dfilt, tick, clr, dev, i_lim,
                 input p_term, i_acc, d_term);
   modport core (input pgain, itime, dtime, dfilt, tick, clr, dev, i_lim,
                 output p_term, i_acc, d_term);
endinterface

// File: rtl/pidc_terms.sv
module pidc_terms
(
   input wire logic core_clk,
   input wire logic srst,
   pidc_cfg_if.core cfg
);
   // Deviation in 0.01 % units; terms in 0.01 % of master frequency
   logic signed [31:0] i_acc_r, i_acc_nxt;
   logic signed [31:0] prev_r, prev_nxt;
   logic signed [31:0] filt_r, filt_nxt;
   logic signed [31:0] p_r, p_nxt;
   logic signed [63:0] wide;
   logic signed [31:0] raw_d;
   logic signed [31:0] step;
   always_comb
   begin
      i_acc_nxt = i_acc_r;
      prev_nxt = prev_r;
      filt_nxt = filt_r;
      p_nxt = p_r;
      wide = 64'sh0;
      raw_d = 32'sh0;
      step = 32'sh0;
      if (cfg.clr)
      begin
         i_acc_nxt = 32'sh0;
         prev_nxt = 32'sh0;
         filt_nxt = 32'sh0;
         p_nxt = 32'sh0;
      end
      else if (cfg.tick)
      begin
         wide = 64'(cfg.dev) * $signed({48'h0, cfg.pgain});
         p_nxt = 32'(wide / 64'sh000000000000000A);
         if (cfg.itime != 16'h0000)
         begin
            // Gain one: deviation fully added after itime (0.01 s = 10 samples)
            step = 32'(64'(cfg.dev) / ($signed({48'h0, cfg.itime}) * 64'sh000000000000000A));
            i_acc_nxt = i_acc_r + step;
            if (i_acc_nxt > cfg.i_lim)
               i_acc_nxt = cfg.i_lim;
            else if (i_acc_nxt < -cfg.i_lim)
               i_acc_nxt = -cfg.i_lim;
         end
         else
            i_acc_nxt = 32'sh0;
         // dtime in 0.01 s equals 10 samples per count
         wide = 64'(cfg.dev - prev_r) * $signed({48'h0, cfg.dtime}) * 64'sh000000000000000A;
         raw_d = 32'(wide);
         // First order lag, time constant dfilt * 100 samples
         if (cfg.dfilt == 16'h0000)
            filt_nxt = raw_d;
         else
            filt_nxt = filt_r + 32'(64'(raw_d - filt_r) /
                       ($signed({48'h0, cfg.dfilt}) * 64'sh0000000000000064));
         prev_nxt = cfg.dev;
      end
   end
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         i_acc_r <= 32'sh0;
         prev_r <= 32'sh0;
         filt_r <= 32'sh0;
         p_r <= 32'sh0;
      end
      else
      begin
         i_acc_r <= i_acc_nxt;
         prev_r <= prev_nxt;
         filt_r <= filt_nxt;
         p_r <= p_nxt;
      end
   end
   assign cfg.p_term = p_r;
   assign cfg.i_acc = i_acc_r;
   assign cfg.d_term = filt_r;
endmodule // pidc_terms

// File: test/pidc_sva.sv
module pidc_sva
#(
   parameter int unsigned SAMPLE_CYCLES = 20
)
(
   input wire logic core_clk,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic drive_running,
   input wire logic pid_active,
   input wire logic feedback_warning,
   input wire logic ramp_stop_req,
   input wire logic coast_stop_req
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   logic [31:0] act_cnt_r;
   logic [31:0] act_cnt_nxt;
   // Run length of the loop, so a warning can be timed against it
   always_comb act_cnt_nxt = pid_active ? act_cnt_r + 32'h1 : 32'h0;
   always_ff @(posedge core_clk) act_cnt_r <= srst ? 32'h0 : act_cnt_nxt;
   a_ready_after_setup: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   a_ready_one_cycle: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   a_rdata_on_read: assert property ($changed(prdata) |-> $past(psel && !pwrite))
      else $error("read data moved without a read");
   a_ramp_needs_warn: assert property ($rose(ramp_stop_req) |-> feedback_warning)
      else $error("ramp stop without warning");
   a_coast_needs_warn: assert property ($rose(coast_stop_req) |-> feedback_warning)
      else $error("coast stop without warning");
   a_one_stop_kind: assert property (!(ramp_stop_req && coast_stop_req))
      else $error("both stop kinds requested");
   a_stop_latched: assert property (ramp_stop_req && drive_running |=> ramp_stop_req)
      else $error("ramp stop dropped while running");
   a_warn_after_time: assert property ($rose(feedback_warning) |-> act_cnt_r >= 32'(99 * SAMPLE_CYCLES))
      else $error("warning before detect time");
endmodule // pidc_sva

// File: test/pidc_fb_model.sv
module pidc_fb_model
(
   input wire logic [15:0] level,
   input wire logic use_current,
   output logic [15:0] volt_out,
   output logic [15:0] curr_out
);
   // Idle channel shows the inverse, so a wrong source pick cannot hide
   assign volt_out = use_current ? ~level : level;
   assign curr_out = use_current ? level : ~level;
endmodule // pidc_fb_model

// File: test/tb_pid_feedback_controller.sv
module tb_pid_feedback_controller;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned SC = 20;
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [15:0] fb_level = 16'h0BB8;
   logic fb_cur = 1'b0;
   logic [15:0] sp = 16'h1B58;
   logic run = 1'b0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, err, pid_act, warn, ramp, coast, irq;
   logic [15:0] volt, curr, freq;
   int mismatches = 0;
   int num_checks = 0;
   logic [11:0] ra [9] = '{12'h000, 12'h004, 12'h008, 12'h010, 12'h014, 12'h018, 12'h01C,
      12'h020, 12'h024};
   logic [15:0] rv [9] = '{16'h0000, 16'h0064, 16'h000A, 16'h0000, 16'h0064, 16'h0000,
      16'h0064, 16'h0258, 16'h0000};
   always #4 core_clk = ~core_clk;
   pidc_top #(.SAMPLE_CYCLES(SC)) dut_u (.core_clk(core_clk), .srst(srst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .voltage_analog_input(volt),
      .current_analog_input(curr), .multi_step_setpoint(sp), .drive_running(run),
      .freq_command(freq), .pid_active(pid_act), .feedback_warning(warn),
      .ramp_stop_req(ramp), .coast_stop_req(coast), .irq(irq));
   pidc_fb_model fb_u (.level(fb_level), .use_current(fb_cur), .volt_out(volt),
      .curr_out(curr));
   task automatic end_sim();
      $display("checks=%0d mismatches=%0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do
      begin
         @(posedge core_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
      if (n >= 50)
      begin
         mismatches++;
         end_sim();
      end
   endtask
   task automatic do_rst();
      run <= 1'b0;
      srst <= 1'b1;
      repeat (12) @(posedge core_clk);
      srst <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   // Model of the P-only path; settings chosen so no rounding enters
   function automatic int exp_freq(int tgt, int fb, int pg, int pos, int ol);
      int dev, f;
      dev = pos ? fb - tgt : tgt - fb;
      f = pg * dev * 6000 / 100000;
      f = f < 0 ? 0 : f;
      return f > ol * 60 ? ol * 60 : f;
   endfunction
   task automatic setup(input logic [15:0] src, pg, ol, det, rng);
      apb(1'b1, 12'h00C, 32'h0);
      apb(1'b1, 12'h034, 32'h1388);
      apb(1'b1, 12'h008, {16'h0, pg});
      apb(1'b1, 12'h01C, {16'h0, ol});
      apb(1'b1, 12'h020, {16'h0, det});
      apb(1'b1, 12'h028, {16'h0, rng});
      apb(1'b1, 12'h000, {16'h0, src});
      run <= 1'b1;
   endtask
   initial
   begin
      logic [31:0] v;
      void'($urandom(29020));
      do_rst();
      for (int i = 0; i < 9; i++)
      begin
         apb(1'b0, ra[i], 32'h0);
         chk(rd, {16'h0, rv[i]});
      end
      v = {16'h0, 16'($urandom)};
      apb(1'b1, 12'h034, v);
      apb(1'b0, 12'h034, 32'h0);
      chk(rd, v);
      apb(1'b0, 12'hFF0, 32'h0);
      chk({31'h0, err}, 32'h1);
      $display("test registers done");
      for (int s = 0; s < 5; s++)
      begin
         do_rst();
         fb_cur <= (s == 2 || s == 4);
         setup(16'(s), 16'h000A, 16'h0064, 16'h0258, 16'h2710);
         wt(10 * SC);
         chk({31'h0, pid_act}, {31'h0, s != 0});
         if (s != 0)
            chk({16'h0, freq}, exp_freq(5000, 3000, 10, s > 2, 100));
      end
      // Negative feedback on the current input, so the limit really bites
      apb(1'b1, 12'h000, 32'h2);
      apb(1'b1, 12'h008, 32'h64);
      apb(1'b1, 12'h01C, 32'h0A);
      wt(10 * SC);
      chk({16'h0, freq}, exp_freq(5000, 3000, 100, 0, 10));
      apb(1'b1, 12'h01C, 32'h64);
      apb(1'b1, 12'h008, 32'h0A);
      apb(1'b1, 12'h030, 32'h1);
      wt(10 * SC);
      chk({16'h0, freq}, exp_freq(7000, 3000, 10, 0, 100));
      apb(1'b1, 12'h014, 32'h0A);
      apb(1'b1, 12'h00C, 32'h1);
      wt(10 * SC);
      // Integral saturates at 10 % of the maximum frequency
      chk({16'h0, freq}, exp_freq(7000, 3000, 10, 0, 100) + 6000 * 10 / 100);
      $display("test loop done");
      for (int a = 0; a < 4; a++)
      begin
         do_rst();
         setup(16'h0001, 16'h000A, 16'h0064, 16'(a < 3), 16'h0064);
         apb(1'b1, 12'h024, 32'(a % 3));
         apb(1'b1, 12'h040, 32'h1);
         wt(90 * SC);
         chk({31'h0, warn}, 32'h0);
         wt(20 * SC);
         chk({29'h0, warn, ramp, coast}, a == 3 ? 0 : {1'b1, a == 1, a == 2});
         chk({31'h0, irq}, {31'h0, a < 3});
         apb(1'b1, 12'h040, 32'h0);
         wt(2);
         chk({31'h0, irq}, 32'h0);
         apb(1'b1, 12'h03C, 32'h7);
         apb(1'b0, 12'h03C, 32'h0);
         chk(rd & 32'h1, 32'h0);
      end
      $display("test supervision done");
      end_sim();
   end
endmodule // tb_pid_feedback_controller
bind pidc_top pidc_sva #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) sva_u (.core_clk(core_clk),
   .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .drive_running(drive_running),
   .pid_active(pid_active), .feedback_warning(feedback_warning),
   .ramp_stop_req(ramp_stop_req), .coast_stop_req(coast_stop_req));
